// >>> include/bsc_pkg.sv
// constants for the boundary-scan order and test-port control block
// assumes one core clock domain; the tester's pins arrive unsynchronised
package bsc_pkg;
    // register byte offsets on the plain register port
    localparam logic [7:0] CTRL_OFS = 8'h35;
    localparam logic [7:0] STAT_OFS = 8'h34;
    localparam logic [7:0] ISTAT_OFS = 8'h36;
    localparam logic [7:0] IMASK_OFS = 8'h37;
    // field positions and reset values
    localparam int DIS_BIT = 7;
    localparam int TRF_BIT = 4;
    localparam logic [7:0] CTRL_RW_MASK = 8'h93;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    // event bits of the interrupt status and mask
    localparam int IRQ_W = 2;
    localparam int EV_TRST = 0;
    localparam int EV_DIS = 1;
    localparam logic [1:0] IRQ_RST = 2'h0;
    // timed change window of the disable bit, in core cycles
    localparam int DIS_WINDOW = 4;
    // instruction codes
    localparam int IR_W = 4;
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_IDCODE = 4'h1;
    localparam logic [3:0] IR_SAMPLE = 4'h2;
    localparam logic [3:0] IR_TRST = 4'hc;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPT = 4'h1;
    // chain layout
    localparam int CHAIN_LEN = 57;
    localparam int RST_CELL = 40;
    localparam int B_TOP = 56;
    localparam int D_TOP = 39;
    localparam int C_TOP = 23;
    localparam int PRT_A = 0;
    localparam int PRT_B = 1;
    localparam int PRT_C = 2;
    localparam int PRT_D = 3;
    // test access port states
    typedef enum logic [15:0] {
        TS_TLR = 16'h0001, TS_RTI = 16'h0002,
        TS_SDR = 16'h0004, TS_CDR = 16'h0008,
        TS_SHDR = 16'h0010, TS_E1DR = 16'h0020,
        TS_PDR = 16'h0040, TS_E2DR = 16'h0080,
        TS_UDR = 16'h0100, TS_SIR = 16'h0200,
        TS_CIR = 16'h0400, TS_SHIR = 16'h0800,
        TS_E1IR = 16'h1000, TS_PIR = 16'h2000,
        TS_E2IR = 16'h4000, TS_UIR = 16'h8000
    } bsc_tap_e;
endpackage : bsc_pkg

// >>> rtl/bsc_ctrl.sv
// boundary-scan chain, test access port and test-port control registers
// assumes tck/tms/tdi and pins are asynchronous; tck well below core_clk/4
//
// Overview of operation
// - cell zero is lsb, first in and out
// - analog cells would sit at the msb end
// - port A pins ordered in reverse order
// - data in first stage, control second
// - port C pins 2-5 have no cells
// - order B, reset cell, D, C, A
// - cell 40 observes reset pin only
// - disable bit zero enables if fuse programmed
// - disable changes on two equal writes within four
// - control resets zero, bits 7,4,1,0 writable
// - test reset flag set by reset register
// - flag cleared by power-on or writing zero
// - reset register one holds device in reset
// - reset instruction selects one-bit reset register
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module bsc_ctrl #(
    parameter logic [31:0] ID_VALUE = 32'h0000_0001 // arbitrary value
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    input wire logic power_on_reset,
    input wire logic test_iface_fuse,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic ext_reset_n_pin,
    input wire logic [7:0] pa_in,
    input wire logic [7:0] pb_in,
    input wire logic [7:0] pc_in,
    input wire logic [7:0] pd_in,
    input wire logic [31:0] core_out,
    input wire logic [31:0] core_dir,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic test_iface_en,
    output logic sys_reset_req,
    output logic [7:0] ctrl_bits
);
    // data cell position of a pin; its control cell sits one below
    function automatic int dpos(input int prt, input int pin);
        case (prt)
            bsc_pkg::PRT_B: dpos = bsc_pkg::B_TOP - 2 * pin;
            bsc_pkg::PRT_D: dpos = bsc_pkg::D_TOP - 2 * pin;
            bsc_pkg::PRT_C:
                dpos = bsc_pkg::C_TOP - 2 * (pin < 2 ? pin : pin - 4);
            default: dpos = 2 * pin + 1; // pin 7 highest
        endcase
    endfunction : dpos

    // port C only has cells on pins 0,1,6,7
    function automatic logic has_cell(input int prt, input int pin);
        has_cell = (prt != bsc_pkg::PRT_C) || pin < 2 || pin > 5;
    endfunction : has_cell

    logic [2:0] tck_sy_ff;
    logic [1:0] tms_sy_ff;
    logic [1:0] tdi_sy_ff;
    logic [32:0] pin_sy1_ff;
    logic [32:0] pin_sy2_ff;
    bsc_pkg::bsc_tap_e tap_ff;
    bsc_pkg::bsc_tap_e nxt_tap;
    logic [3:0] ir_ff;
    logic [3:0] ir_sh_ff;
    logic [56:0] bs_sh_ff;
    logic [56:0] bs_upd_ff;
    logic [56:0] nxt_cap;
    logic [31:0] id_sh_ff;
    logic byp_ff;
    logic rst_reg_ff;
    logic tdo_ff;
    logic tdo_oe_ff;
    logic [7:0] ctrl_ff;
    logic arm_ff;
    logic pval_ff;
    logic [2:0] win_ff;
    logic trf_ff;
    logic [1:0] ist_ff;
    logic [1:0] imask_ff;
    logic irq_ff;
    logic [7:0] rdata_ff;
    logic [31:0] pin_out_ff;
    logic [31:0] pin_oe_ff;
    logic en_ff;
    logic tck_rise;
    logic tck_fall;
    logic ext_on;
    logic wr_ctrl;
    logic wr_stat;
    logic dis_chg;

    // two-stage synchronisers; the first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tck_sy_ff <= 3'h0;
            tms_sy_ff <= 2'h0;
            tdi_sy_ff <= 2'h0;
            pin_sy1_ff <= 33'h0;
            pin_sy2_ff <= 33'h0;
        end else if (clk_en) begin
            tck_sy_ff <= {tck_sy_ff[1:0], tck};
            tms_sy_ff <= {tms_sy_ff[0], tms};
            tdi_sy_ff <= {tdi_sy_ff[0], tdi};
            pin_sy1_ff <= {ext_reset_n_pin, pd_in, pc_in, pb_in, pa_in};
            pin_sy2_ff <= pin_sy1_ff;
        end
    end

    // edges read stages two and three, never stage one
    assign tck_rise = tck_sy_ff[1] & ~tck_sy_ff[2];
    assign tck_fall = ~tck_sy_ff[1] & tck_sy_ff[2];
    assign wr_ctrl = reg_wr && reg_addr == bsc_pkg::CTRL_OFS;
    assign wr_stat = reg_wr && reg_addr == bsc_pkg::STAT_OFS;

    // tap next state, sixteen states; exit2 with tms high goes to exit1, not update
    always_comb begin
        nxt_tap = tap_ff;
        case (tap_ff)
            bsc_pkg::TS_TLR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_TLR : bsc_pkg::TS_RTI;
            bsc_pkg::TS_RTI, bsc_pkg::TS_UDR, bsc_pkg::TS_UIR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_SDR : bsc_pkg::TS_RTI;
            bsc_pkg::TS_SDR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_SIR : bsc_pkg::TS_CDR;
            bsc_pkg::TS_CDR, bsc_pkg::TS_SHDR, bsc_pkg::TS_E2DR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_E1DR
                                       : bsc_pkg::TS_SHDR;
            bsc_pkg::TS_E1DR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_UDR : bsc_pkg::TS_PDR;
            bsc_pkg::TS_PDR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_E2DR : bsc_pkg::TS_PDR;
            bsc_pkg::TS_SIR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_TLR : bsc_pkg::TS_CIR;
            bsc_pkg::TS_CIR, bsc_pkg::TS_SHIR, bsc_pkg::TS_E2IR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_E1IR
                                       : bsc_pkg::TS_SHIR;
            bsc_pkg::TS_E1IR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_UIR : bsc_pkg::TS_PIR;
            bsc_pkg::TS_PIR:
                nxt_tap = tms_sy_ff[1] ? bsc_pkg::TS_E2IR : bsc_pkg::TS_PIR;
            default: nxt_tap = bsc_pkg::TS_TLR;
        endcase
    end

    // interface enable: fuse programmed and disable bit clear
    always_ff @(posedge core_clk) begin
        if (reset)
            en_ff <= 1'b0;
        else if (clk_en)
            en_ff <= test_iface_fuse & ~ctrl_ff[bsc_pkg::DIS_BIT];
    end

    // tap state; held in reset while the interface is disabled
    always_ff @(posedge core_clk) begin
        if (reset || (clk_en && !en_ff))
            tap_ff <= bsc_pkg::TS_TLR;
        else if (clk_en && tck_rise)
            tap_ff <= nxt_tap;
    end

    // instruction register; reset instruction leaves the tap alone
    always_ff @(posedge core_clk) begin
        if (reset || (clk_en && tap_ff == bsc_pkg::TS_TLR)) begin
            ir_ff <= bsc_pkg::IR_IDCODE;
            ir_sh_ff <= bsc_pkg::IR_CAPT;
        end else if (clk_en && tck_rise) begin
            if (tap_ff == bsc_pkg::TS_CIR)
                ir_sh_ff <= bsc_pkg::IR_CAPT;
            else if (tap_ff == bsc_pkg::TS_SHIR)
                ir_sh_ff <= {tdi_sy_ff[1], ir_sh_ff[3:1]};
        end else if (clk_en && tck_fall && tap_ff == bsc_pkg::TS_UIR) begin
            ir_ff <= ir_sh_ff;
        end
    end

    // capture image: no analog cells on this part, so none at the top
    // port C pins 2-5 serve as tap pins and get no cells
    always_comb begin
        nxt_cap = 57'h0;
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 8; i++) begin
                if (has_cell(p, i)) begin
                    // first stage holds pin data
                    nxt_cap[dpos(p, i)] = pin_sy2_ff[8 * p + i];
                    // second stage holds output control
                    nxt_cap[dpos(p, i) - 1] = core_dir[8 * p + i];
                end
            end
        end
        nxt_cap[bsc_pkg::RST_CELL] = pin_sy2_ff[32];
    end

    // data registers: lsb is shifted out first, tdi enters at msb
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bs_sh_ff <= 57'h0;
            id_sh_ff <= 32'h0;
            byp_ff <= 1'b0;
        end else if (clk_en && tck_rise) begin
            if (tap_ff == bsc_pkg::TS_CDR) begin
                bs_sh_ff <= nxt_cap;
                id_sh_ff <= ID_VALUE;
                byp_ff <= 1'b0;
            end else if (tap_ff == bsc_pkg::TS_SHDR) begin
                case (ir_ff)
                    bsc_pkg::IR_EXTEST, bsc_pkg::IR_SAMPLE:
                        bs_sh_ff <= {tdi_sy_ff[1], bs_sh_ff[56:1]};
                    bsc_pkg::IR_IDCODE:
                        id_sh_ff <= {tdi_sy_ff[1], id_sh_ff[31:1]};
                    default: byp_ff <= tdi_sy_ff[1];
                endcase
            end
        end
    end

    // update latches; the observe-only cell drives nothing
    always_ff @(posedge core_clk) begin
        if (reset)
            bs_upd_ff <= 57'h0;
        else if (clk_en && tck_fall && tap_ff == bsc_pkg::TS_UDR &&
                 (ir_ff == bsc_pkg::IR_EXTEST ||
                  ir_ff == bsc_pkg::IR_SAMPLE))
            bs_upd_ff <= bs_sh_ff;
    end

    // one-bit reset register; its output is used unlatched
    always_ff @(posedge core_clk) begin
        if (reset || (clk_en && !en_ff))
            rst_reg_ff <= 1'b0;
        else if (clk_en && tck_rise && tap_ff == bsc_pkg::TS_SHDR &&
                 ir_ff == bsc_pkg::IR_TRST)
            rst_reg_ff <= tdi_sy_ff[1];
    end

    // tdo changes on the falling tck edge, driven only while shifting
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (clk_en && tck_fall) begin
            tdo_oe_ff <= tap_ff == bsc_pkg::TS_SHDR ||
                         tap_ff == bsc_pkg::TS_SHIR;
            if (tap_ff == bsc_pkg::TS_SHIR)
                tdo_ff <= ir_sh_ff[0];
            else
                case (ir_ff)
                    bsc_pkg::IR_EXTEST, bsc_pkg::IR_SAMPLE:
                        tdo_ff <= bs_sh_ff[0];
                    bsc_pkg::IR_IDCODE: tdo_ff <= id_sh_ff[0];
                    bsc_pkg::IR_TRST: tdo_ff <= rst_reg_ff;
                    default: tdo_ff <= byp_ff;
                endcase
        end
    end

    // pins follow the update latches as soon as extest is loaded
    assign ext_on = ir_ff == bsc_pkg::IR_EXTEST;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_out_ff <= 32'h0;
            pin_oe_ff <= 32'h0;
        end else if (clk_en) begin
            for (int p = 0; p < 4; p++) begin
                for (int i = 0; i < 8; i++) begin
                    if (ext_on && has_cell(p, i)) begin
                        pin_out_ff[8 * p + i] <= bs_upd_ff[dpos(p, i)];
                        pin_oe_ff[8 * p + i] <= bs_upd_ff[dpos(p, i) - 1];
                    end else begin
                        pin_out_ff[8 * p + i] <= core_out[8 * p + i];
                        pin_oe_ff[8 * p + i] <= core_dir[8 * p + i];
                    end
                end
            end
        end
    end

    // control register; a stray single write cannot flip the disable
    // bit, which would lock out or expose the test port
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_ff <= bsc_pkg::CTRL_RST;
            arm_ff <= 1'b0;
            pval_ff <= 1'b0;
            win_ff <= 3'h0;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl_ff[bsc_pkg::DIS_BIT - 1:0] <=
                    reg_wdata[bsc_pkg::DIS_BIT - 1:0] &
                    bsc_pkg::CTRL_RW_MASK[bsc_pkg::DIS_BIT - 1:0];
                if (arm_ff && pval_ff == reg_wdata[bsc_pkg::DIS_BIT]) begin
                    ctrl_ff[bsc_pkg::DIS_BIT] <=
                        reg_wdata[bsc_pkg::DIS_BIT];
                    arm_ff <= 1'b0;
                end else begin
                    // first write, or a mismatch: arm afresh
                    arm_ff <= 1'b1;
                    pval_ff <= reg_wdata[bsc_pkg::DIS_BIT];
                    win_ff <= 3'h0;
                end
            end else if (arm_ff) begin
                if (win_ff == 3'(bsc_pkg::DIS_WINDOW - 1))
                    arm_ff <= 1'b0; // window closed
                else
                    win_ff <= win_ff + 3'h1;
            end
        end
    end
    assign dis_chg = wr_ctrl && arm_ff &&
                     pval_ff == reg_wdata[bsc_pkg::DIS_BIT] &&
                     pval_ff != ctrl_ff[bsc_pkg::DIS_BIT];

    // test reset flag; a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (reset)
            trf_ff <= bsc_pkg::STAT_RST[bsc_pkg::TRF_BIT];
        else if (clk_en) begin
            if (rst_reg_ff)
                trf_ff <= 1'b1;
            else if (power_on_reset ||
                     (wr_stat && !reg_wdata[bsc_pkg::TRF_BIT]))
                trf_ff <= 1'b0;
        end
    end

    // sticky events cleared by writing one, mask gates the output
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ist_ff <= bsc_pkg::IRQ_RST;
            imask_ff <= bsc_pkg::IRQ_RST;
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            for (int k = 0; k < bsc_pkg::IRQ_W; k++) begin
                if (reg_wr && reg_addr == bsc_pkg::ISTAT_OFS &&
                    reg_wdata[k])
                    ist_ff[k] <= 1'b0;
            end
            if (rst_reg_ff && !trf_ff)
                ist_ff[bsc_pkg::EV_TRST] <= 1'b1;
            if (dis_chg)
                ist_ff[bsc_pkg::EV_DIS] <= 1'b1;
            if (reg_wr && reg_addr == bsc_pkg::IMASK_OFS)
                imask_ff <= reg_wdata[bsc_pkg::IRQ_W - 1:0];
            irq_ff <= |(ist_ff & imask_ff);
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (reset)
            rdata_ff <= 8'h00;
        else if (clk_en) begin
            rdata_ff <= 8'h00;
            if (reg_rd)
                case (reg_addr)
                    bsc_pkg::CTRL_OFS: rdata_ff <= ctrl_ff;
                    bsc_pkg::STAT_OFS:
                        rdata_ff <= {3'h0, trf_ff, 4'h0};
                    bsc_pkg::ISTAT_OFS: rdata_ff <= {6'h0, ist_ff};
                    bsc_pkg::IMASK_OFS: rdata_ff <= {6'h0, imask_ff};
                    default: rdata_ff <= 8'h00;
                endcase
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq = irq_ff;
    assign tdo = tdo_ff;
    assign tdo_oe = tdo_oe_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign test_iface_en = en_ff;
    assign sys_reset_req = rst_reg_ff; // holds reset while one
    assign ctrl_bits = ctrl_ff;
endmodule : bsc_ctrl

// >>> bench/bsc_ctrl_monitor.sv
// checker for the test-port control block: register port, disable bit
// assumes a bind onto bsc_ctrl and one core clock domain
`timescale 1ns/1ps
module bsc_ctrl_mon (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic test_iface_fuse,
    input wire logic test_iface_en,
    input wire logic sys_reset_req,
    input wire logic [7:0] ctrl_bits
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [3:0] age_ff;
    logic last_ff;
    logic ctl_wr;
    assign ctl_wr = clk_en && reg_wr && reg_addr == bsc_pkg::CTRL_OFS;
    // age of the previous control write, saturating so it never wraps
    always_ff @(posedge core_clk) begin
        if (reset) begin
            age_ff <= 4'hf;
            last_ff <= 1'b0;
        end else if (ctl_wr) begin
            age_ff <= 4'h1;
            last_ff <= reg_wdata[7];
        end else if (clk_en && age_ff != 4'hf) begin
            age_ff <= age_ff + 4'h1;
        end
    end
    // register port answers
    rdata_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside answer cycle");
    ctrl_read_a: assert property (clk_en && reg_rd &&
        reg_addr == bsc_pkg::CTRL_OFS |=> reg_rdata == $past(ctrl_bits))
        else $error("control read data wrong");
    unmapped_rd_a: assert property (clk_en && reg_rd &&
        reg_addr[7:2] != 6'h0d |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    ro_bits_a: assert property ((ctrl_bits & ~bsc_pkg::CTRL_RW_MASK) == 8'h00)
        else $error("read-only control bit set");
    ctrl_rw_a: assert property (ctl_wr |=>
        (ctrl_bits & 8'h13) == ($past(reg_wdata) & 8'h13))
        else $error("plain control bits not written");
    reset_val_a: assert property (disable iff (1'b0) reset && clk_en |=>
        ctrl_bits == 8'h00 && !sys_reset_req)
        else $error("control not cleared by reset");
    // enable follows fuse and disable bit once both settled
    iface_en_a: assert property (!$past(reset) && !$past(reset, 2) &&
        $past(clk_en) && $stable(ctrl_bits[7]) && $stable(test_iface_fuse)
        |-> test_iface_en == (test_iface_fuse && !ctrl_bits[7]))
        else $error("interface enable wrong");
    dis_hold_a: assert property (ctl_wr && (age_ff > 4'h4 ||
        last_ff != reg_wdata[7]) |=> $stable(ctrl_bits[7]))
        else $error("disable bit changed without timed pair");
    dis_pair_a: assert property (ctl_wr && age_ff <= 4'h4 &&
        last_ff == reg_wdata[7] |=> ctrl_bits[7] == $past(reg_wdata[7]))
        else $error("disable bit ignored timed pair");
    rst_reg_off_a: assert property (!test_iface_en [*3] |-> !sys_reset_req)
        else $error("reset request while interface disabled");
endmodule : bsc_ctrl_mon

bind bsc_ctrl bsc_ctrl_mon mon_u (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .test_iface_fuse(test_iface_fuse),
    .test_iface_en(test_iface_en),
    .sys_reset_req(sys_reset_req),
    .ctrl_bits(ctrl_bits)
);

// >>> bench/bsc_tester.sv
// boundary-scan tester model: tap walks and lsb-first shifts
// assumes core_clk of 100 ns; tck of 800 ns, held low between frames
`timescale 1ns/1ps
module bsc_tester (
    input wire logic core_clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one tck period; tdo read just before the rise, tdi spoilt late
    task automatic tap_bit(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge core_clk);
        q = tdo;
        tck <= 1'b1;
        repeat (3) @(posedge core_clk);
        tdi <= ~d; // stale data must not pass for a real bit
        @(posedge core_clk);
        tck <= 1'b0;
    endtask : tap_bit
    // five ones reach logic reset from any state but the two pause states, then idle
    task automatic tap_reset;
        logic q;
        @(posedge core_clk);
        for (int i = 0; i < 5; i++) begin
            tap_bit(1'b1, 1'b0, q);
        end
        tap_bit(1'b0, 1'b0, q);
    endtask : tap_reset
    // idle to shift, n bits, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic q;
        dout = 64'h0;
        @(posedge core_clk);
        tap_bit(1'b1, 1'b0, q);
        if (ir) begin
            tap_bit(1'b1, 1'b0, q);
        end
        tap_bit(1'b0, 1'b0, q);
        tap_bit(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tap_bit(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tap_bit(1'b1, 1'b0, q);
        tap_bit(1'b0, 1'b0, q);
    endtask : scan
endmodule : bsc_tester

// >>> bench/bsc_ctrl_bench.sv
// self-checking bench: register port tasks and scans through the tester
// assumes bsc_pkg, bsc_ctrl, the checker and the tester compiled first
`timescale 1ns/1ps
module bsc_ctrl_bench;
    localparam logic [31:0] ID_SET = 32'h0c3a_5e71; // arbitrary value
    localparam logic [63:0] PAT = 64'h0135_79bd_f024_68ac;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic power_on_reset = 1'b0;
    logic test_iface_fuse = 1'b1;
    logic ext_reset_n_pin = 1'b1;
    logic [31:0] pins = 32'h2f81_c635;
    logic [31:0] core_dir = 32'h9a3c_e517;
    logic [7:0] reg_rdata, ctrl_bits, rv;
    logic irq, tck, tms, tdi, tdo, tdo_oe, test_iface_en, sys_reset_req;
    logic [31:0] pin_out, pin_oe;
    logic [63:0] sv, ev, eo, ee, mk;
    int d;
    int error_cnt = 0;
    int num_checks = 0;
    always #50 core_clk = ~core_clk;
    bsc_ctrl #(.ID_VALUE(ID_SET)) dut_u (
        .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .power_on_reset(power_on_reset), .test_iface_fuse(test_iface_fuse),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .ext_reset_n_pin(ext_reset_n_pin), .pa_in(pins[7:0]),
        .pb_in(pins[15:8]), .pc_in(pins[23:16]), .pd_in(pins[31:24]),
        .core_out(32'h0000_0000), .core_dir(core_dir), .pin_out(pin_out),
        .pin_oe(pin_oe), .test_iface_en(test_iface_en),
        .sys_reset_req(sys_reset_req), .ctrl_bits(ctrl_bits));
    bsc_tester tst_u (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask : rc
    // data cell position of a pin; control cell lies just below it
    function automatic int dpos(int p, int i);
        case (p)
            0: return 2 * i + 1;
            1: return 56 - 2 * i;
            3: return 39 - 2 * i;
            default: return (i < 2) ? 23 - 2 * i : (i > 5) ? 31 - 2 * i : -1;
        endcase
    endfunction : dpos
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // watchdog well beyond the few thousand cycles the tests take
    initial begin
        #5_000_000;
        error_cnt++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk(test_iface_en, 1'b1);
        rc(bsc_pkg::CTRL_OFS, 8'h00);
        rc(bsc_pkg::STAT_OFS, 8'h00);
        rc(8'h00, 8'h00);
        // a write while the clock enable is low must leave no trace
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr(bsc_pkg::CTRL_OFS, 8'h13);
        clk_en <= 1'b1;
        rc(bsc_pkg::CTRL_OFS, 8'h00);
        wr(bsc_pkg::CTRL_OFS, 8'hff);
        rc(bsc_pkg::CTRL_OFS, 8'h13);
        wr(bsc_pkg::CTRL_OFS, 8'h00);
        wr(bsc_pkg::IMASK_OFS, 8'h00);
        wr(bsc_pkg::CTRL_OFS, 8'h80); // no debug session running
        wr(bsc_pkg::CTRL_OFS, 8'h80);
        rc(bsc_pkg::CTRL_OFS, 8'h80);
        chk(test_iface_en, 1'b0);
        chk(irq, 1'b0);
        rc(bsc_pkg::ISTAT_OFS, 8'h02);
        wr(bsc_pkg::IMASK_OFS, 8'h02);
        repeat (2) @(negedge core_clk);
        chk(irq, 1'b1);
        wr(bsc_pkg::ISTAT_OFS, 8'h02);
        repeat (2) @(negedge core_clk);
        chk(irq, 1'b0);
        wr(bsc_pkg::CTRL_OFS, 8'h00);
        repeat (5) @(posedge core_clk);
        wr(bsc_pkg::CTRL_OFS, 8'h00);
        @(negedge core_clk);
        chk(ctrl_bits, 8'h80);
        wr(bsc_pkg::CTRL_OFS, 8'h00);
        rc(bsc_pkg::CTRL_OFS, 8'h00);
        wr(bsc_pkg::ISTAT_OFS, 8'h03);
        tst_u.tap_reset();
        tst_u.scan(1'b0, 32, 64'h0, sv);
        chk(sv, 64'(ID_SET));
        chk(tdo_oe, 1'b0);
        ev = 64'h0;
        ev[40] = ext_reset_n_pin;
        {eo, ee, mk} = '0;
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 8; i++) begin
                d = dpos(p, i);
                if (d >= 0) begin
                    ev[d] = pins[8 * p + i];
                    ev[d - 1] = core_dir[8 * p + i];
                    eo[8 * p + i] = PAT[d];
                    ee[8 * p + i] = PAT[d - 1];
                    mk[8 * p + i] = 1'b1;
                end
            end
        end
        tst_u.scan(1'b1, 4, 64'(bsc_pkg::IR_SAMPLE), sv);
        tst_u.scan(1'b0, 57, PAT, sv);
        chk(sv, ev);
        tst_u.scan(1'b1, 4, 64'(bsc_pkg::IR_EXTEST), sv);
        tst_u.scan(1'b0, 57, PAT, sv);
        @(negedge core_clk);
        chk(sv, ev);
        chk(pin_out & mk[31:0], eo);
        chk(pin_oe & mk[31:0], ee);
        tst_u.scan(1'b1, 4, 64'(bsc_pkg::IR_TRST), sv);
        tst_u.scan(1'b0, 1, 64'h1, sv);
        @(negedge core_clk);
        chk(sys_reset_req, 1'b1);
        rc(bsc_pkg::STAT_OFS, 8'h10);
        rc(bsc_pkg::ISTAT_OFS, 8'h01);
        tst_u.scan(1'b0, 1, 64'h0, sv);
        @(negedge core_clk);
        chk(sys_reset_req, 1'b0); // instruction kept, tap not reset
        rc(bsc_pkg::STAT_OFS, 8'h10);
        wr(bsc_pkg::STAT_OFS, 8'h00);
        rc(bsc_pkg::STAT_OFS, 8'h00);
        tst_u.scan(1'b0, 1, 64'h1, sv);
        tst_u.scan(1'b0, 1, 64'h0, sv);
        @(posedge core_clk);
        power_on_reset <= 1'b1;
        @(posedge core_clk);
        power_on_reset <= 1'b0;
        rc(bsc_pkg::STAT_OFS, 8'h00);
        @(posedge core_clk);
        test_iface_fuse <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk(test_iface_en, 1'b0);
        close_out();
    end
endmodule : bsc_ctrl_bench
